// *** dual_role_pkg.sv ***
package dual_role_pkg;
  // ----------------------------------------
  // clock and timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int DEGLITCH_NS = 625;
  localparam int SHORT_DET_NS = 5000;
  // least times round up to whole cycles
  localparam int DEGLITCH_CYC = (DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SHORT_DET_CYC = (SHORT_DET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEG_W = 4;
  localparam int SHORT_W = 7;
  localparam logic [DEG_W-1:0] DEG_LAST = DEG_W'(DEGLITCH_CYC - 1);
  localparam logic [SHORT_W-1:0] SHORT_LAST = SHORT_W'(SHORT_DET_CYC - 1);

  // ----------------------------------------
  // pin synchroniser lanes
  // ----------------------------------------
  localparam int PIN_N = 4;
  localparam int LANE_FLAG = 0;
  localparam int LANE_PHASE = 1;
  localparam int LANE_LEVEL = 2;
  localparam int LANE_ROLE = 3;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic FWD_RESET = 1'b1;
  localparam logic LEVEL_RESET = 1'b0;
  localparam logic ROLE_SLAVE = 1'b0;
  localparam logic ROLE_MASTER = 1'b1;
endpackage : dual_role_pkg

// *** input_deglitch.sv ***
`timescale 1ns/10ps
// up/reset counter: any change of din restarts it, a value is taken once it has stood long enough
module input_deglitch #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic din,
  output logic q
);
  logic prev;
  logic [dual_role_pkg::DEG_W-1:0] count;

  // --------------------------------
  // stability counter
  // --------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev <= RESET_VAL;
      count <= '0;
    end else begin
      prev <= din;
      if (din != prev) begin
        count <= '0; // glitch of either slope restarts the count
      end else if (count != dual_role_pkg::DEG_LAST) begin
        count <= count + 1'b1;
      end
    end
  end

  // accept the value only after a full stable window
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= RESET_VAL;
    end else if (din == prev && count == dual_role_pkg::DEG_LAST) begin
      q <= din;
    end
  end
endmodule : input_deglitch

// *** dual_role_config_pin_logic.sv ***
// Notes on behaviour
// - slave flag high while receive queue nonempty
// - master reads flag pin as clock polarity
// - flag pin pull-down on in latch, normal
// - slave enables flag driver in normal state
// - driven versus readback mismatch trips driver off
// - tripped driver returns at next wakeup
// - slave pushes frames only when forwarding enabled
// - forward enable captured at chip select
// - master latches phase pin as clock phase
// - phase pin pull-up on only in latch, normal; off in standby
// - level select zero low, one high amplitude
// - slave captures level, applies after frame sent
// - newest captured level wins, no pipelining
// - master applies deglitched level at frame start
// - level latched during wakeup from standby
// - initial level latched during first power-up
// - role select latched in configuration latch state
// - short filter needs five microseconds mismatch
// - enable and level deglitched by up/reset counter
// - logic runs from one main clock
`timescale 1ns/10ps
module dual_role_config_pin_logic (
  input wire logic sys_clk,
  input wire logic rst_n,
  // device state from the sleep and wake machine
  input wire logic stateCfgLatch,
  input wire logic stateNormal,
  input wire logic stateStandby,
  input wire logic wakeupStart,
  // events from the datapath, same clock
  input wire logic csAssert,
  input wire logic frameIn,
  input wire logic rxQueueNotEmpty,
  input wire logic isoTxStart,
  input wire logic isoTxDone,
  // pins
  input wire logic flagOrPolarityIn,
  output logic flagOrPolarityOut,
  output logic flagOrPolarityOe,
  output logic flagPullDownEn,
  output logic flagInBufEn,
  input wire logic enableOrPhaseIn,
  output logic phasePullUpEn,
  input wire logic isoTxLevelSelectIn,
  input wire logic roleSelectIn,
  output logic roleInBufEn,
  // decoded configuration
  output logic masterRole,
  output logic clkPolarity,
  output logic clkPhase,
  output logic txPushFrame,
  output logic isoTxLevelHigh,
  output logic flagShortTripped
);
  // -----------------------------------------------------------
  // pin synchronisers
  // -----------------------------------------------------------
  logic [dual_role_pkg::PIN_N-1:0] pinRaw;
  logic [dual_role_pkg::PIN_N-1:0] pinMeta;
  logic [dual_role_pkg::PIN_N-1:0] pinSync;

  assign pinRaw[dual_role_pkg::LANE_FLAG] = flagOrPolarityIn;
  assign pinRaw[dual_role_pkg::LANE_PHASE] = enableOrPhaseIn;
  assign pinRaw[dual_role_pkg::LANE_LEVEL] = isoTxLevelSelectIn;
  assign pinRaw[dual_role_pkg::LANE_ROLE] = roleSelectIn;

  // one main clock for every stage and counter, so filter times are whole cycles
  // two stages per pin; the first stage feeds only the second
  for (genvar i = 0; i < dual_role_pkg::PIN_N; i++) begin : g_sync
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        pinMeta[i] <= 1'b0;
        pinSync[i] <= 1'b0;
      end else begin
        pinMeta[i] <= pinRaw[i];
        pinSync[i] <= pinMeta[i];
      end
    end
  end

  // -----------------------------------------------------------
  // deglitch filters on the slow control pins
  // -----------------------------------------------------------
  logic fwdClean;
  logic levelClean;

  input_deglitch #(.RESET_VAL(dual_role_pkg::FWD_RESET)) u_fwd_deglitch (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .din(pinSync[dual_role_pkg::LANE_PHASE]),
    .q(fwdClean)
  );

  input_deglitch #(.RESET_VAL(dual_role_pkg::LEVEL_RESET)) u_level_deglitch (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .din(pinSync[dual_role_pkg::LANE_LEVEL]),
    .q(levelClean)
  );

  // -----------------------------------------------------------
  // role and master clock configuration
  // -----------------------------------------------------------
  // straps are taken by the clock while the latch state lasts, never by the reset itself
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      masterRole <= dual_role_pkg::ROLE_SLAVE;
      clkPolarity <= 1'b0;
      clkPhase <= 1'b0;
    end else if (stateCfgLatch) begin
      masterRole <= pinSync[dual_role_pkg::LANE_ROLE];
      clkPolarity <= pinSync[dual_role_pkg::LANE_FLAG]; // 0 idle low, 1 idle high
      clkPhase <= pinSync[dual_role_pkg::LANE_PHASE]; // 0 first edge, 1 second edge
    end
  end

  // -----------------------------------------------------------
  // pull resistors and input buffers
  // -----------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      flagPullDownEn <= 1'b0;
      phasePullUpEn <= 1'b0;
      roleInBufEn <= 1'b0;
      flagInBufEn <= 1'b1;
    end else begin
      flagPullDownEn <= stateCfgLatch | stateNormal;
      phasePullUpEn <= (stateCfgLatch | stateNormal) & ~stateStandby; // saves standby current
      roleInBufEn <= stateCfgLatch; // strap no longer needed afterwards
      flagInBufEn <= 1'b1; // readback needed in both roles
    end
  end

  // -----------------------------------------------------------
  // receive pending flag driver and short detection
  // -----------------------------------------------------------
  logic [dual_role_pkg::SHORT_W-1:0] shortCount;
  logic mismatch;
  logic slaveNormal;
  logic next_trip;

  assign slaveNormal = stateNormal & (masterRole == dual_role_pkg::ROLE_SLAVE);
  // readback lags the driver by the synchroniser; far shorter than the filter
  assign mismatch = flagOrPolarityOe & (flagOrPolarityOut != pinSync[dual_role_pkg::LANE_FLAG]);

  // flag value and enable
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      flagOrPolarityOut <= 1'b0;
      flagOrPolarityOe <= 1'b0;
    end else begin
      flagOrPolarityOut <= slaveNormal & rxQueueNotEmpty;
      // master never drives; a tripped driver stays off
      flagOrPolarityOe <= slaveNormal & ~flagShortTripped & ~next_trip;
    end
  end

  // mismatch filter; a real short holds for the whole window
  assign next_trip = mismatch & (shortCount == dual_role_pkg::SHORT_LAST);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      shortCount <= '0;
    end else if (!mismatch) begin
      shortCount <= '0;
    end else if (shortCount != dual_role_pkg::SHORT_LAST) begin
      shortCount <= shortCount + 1'b1;
    end
  end

  // sticky trip; a trip in the wakeup cycle wins over the re-engage
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      flagShortTripped <= 1'b0;
    end else if (next_trip) begin
      flagShortTripped <= 1'b1;
    end else if (wakeupStart) begin
      flagShortTripped <= 1'b0;
    end
  end

  // -----------------------------------------------------------
  // transmit forwarding
  // -----------------------------------------------------------
  logic fwdCaptured;

  // held for the whole frame so nothing in flight is chopped
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fwdCaptured <= dual_role_pkg::FWD_RESET;
    end else if (slaveNormal && csAssert) begin
      fwdCaptured <= fwdClean;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      txPushFrame <= 1'b0;
    end else begin
      txPushFrame <= slaveNormal & frameIn & fwdCaptured; // dropped when disabled
    end
  end

  // -----------------------------------------------------------
  // isolated line amplitude
  // -----------------------------------------------------------
  logic pendingLevel;

  // one pending slot only: a later capture overwrites an earlier one
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pendingLevel <= dual_role_pkg::LEVEL_RESET;
    end else if (stateCfgLatch || wakeupStart) begin
      pendingLevel <= pinSync[dual_role_pkg::LANE_LEVEL];
    end else if (slaveNormal && csAssert) begin
      pendingLevel <= levelClean;
    end
  end

  // applied amplitude: 0 low, 1 high
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      isoTxLevelHigh <= dual_role_pkg::LEVEL_RESET;
    end else if (stateCfgLatch) begin
      isoTxLevelHigh <= pinSync[dual_role_pkg::LANE_LEVEL];
    end else if (wakeupStart) begin
      isoTxLevelHigh <= pinSync[dual_role_pkg::LANE_LEVEL];
    end else if (slaveNormal && isoTxDone) begin
      isoTxLevelHigh <= pendingLevel;
    end else if (stateNormal && masterRole && isoTxStart) begin
      isoTxLevelHigh <= levelClean;
    end
  end

  // -----------------------------------------------------------
  // checks
  // -----------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  chk_flag_follows_queue: assert property (
    slaveNormal |=> flagOrPolarityOut == $past(rxQueueNotEmpty))
    else $error("pending flag does not follow queue state");

  chk_master_no_drive: assert property (
    masterRole && !stateCfgLatch |=> !flagOrPolarityOe)
    else $error("flag driver enabled in master role");

  chk_pulldown_states: assert property (
    (stateCfgLatch || stateNormal) |=> flagPullDownEn)
    else $error("flag pull-down off in latch or normal state");

  chk_pullup_standby: assert property (
    stateStandby && !stateCfgLatch && !stateNormal |=> !phasePullUpEn)
    else $error("phase pull-up on in standby");

  chk_short_trip_time: assert property (
    !mismatch ##1 mismatch [*8] |-> !flagShortTripped || $past(flagShortTripped, 8))
    else $error("short trip before filter time");

  chk_trip_off_drive: assert property (
    flagShortTripped && !wakeupStart |=> !flagOrPolarityOe)
    else $error("driver enabled while tripped");

  chk_wake_reengage: assert property (
    flagShortTripped && wakeupStart && !next_trip |=> !flagShortTripped)
    else $error("trip not cleared by wakeup");

  chk_drop_disabled: assert property (
    txPushFrame |-> $past(fwdCaptured) && $past(frameIn))
    else $error("frame pushed while forwarding disabled");

  chk_level_slave_hold: assert property (
    slaveNormal && !isoTxDone && !wakeupStart && !stateCfgLatch |=> $stable(isoTxLevelHigh))
    else $error("slave amplitude changed outside frame end");

  chk_level_apply: assert property (
    slaveNormal && isoTxDone && !wakeupStart && !stateCfgLatch |=> isoTxLevelHigh == $past(pendingLevel))
    else $error("captured amplitude not applied at frame end");

  chk_role_latch: assert property (
    stateCfgLatch |=> masterRole == $past(pinSync[dual_role_pkg::LANE_ROLE]))
    else $error("role not latched in configuration state");

  chk_fwd_capture: assert property (
    slaveNormal && csAssert |=> fwdCaptured == $past(fwdClean))
    else $error("forward enable not captured at chip select");

  chk_slave_drive_on: assert property (
    slaveNormal && !flagShortTripped && !next_trip |=> flagOrPolarityOe)
    else $error("flag driver off in slave normal state");

  cov_short_trip: cover property (!flagShortTripped ##1 flagShortTripped);
  cov_wake_reengage: cover property (flagShortTripped ##1 !flagShortTripped);
  cov_frame_dropped: cover property (slaveNormal && frameIn && !fwdCaptured);
  cov_level_switch: cover property (stateNormal && $changed(isoTxLevelHigh));
endmodule : dual_role_config_pin_logic

// *** host_mcu_model.sv ***
`timescale 1ns/10ps
// ----------------------------------------
// host microcontroller pin model
// ----------------------------------------
module host_mcu_model (
  input wire logic sys_clk,
  input wire logic flagOrPolarityOut,
  input wire logic flagOrPolarityOe,
  input wire logic flagPullDownEn,
  input wire logic drivePolarity,
  input wire logic polarityVal,
  input wire logic shortOn,
  input wire logic shortVal,
  input wire logic fwdVal,
  input wire logic levelVal,
  input wire logic releaseLevel,
  input wire logic roleVal,
  output logic flagOrPolarityIn,
  output logic enableOrPhaseIn,
  output logic isoTxLevelSelectIn,
  output logic roleSelectIn
);
  logic lastFlag;
  // a floating flag pin flips each cycle, so a stale level never passes for a driven one
  always_ff @(posedge sys_clk) begin
    lastFlag <= flagOrPolarityIn;
  end
  // flag pin level: a short beats every driver, then strap, device driver, pull-down
  always_comb begin
    if (shortOn) flagOrPolarityIn = shortVal;
    else if (drivePolarity) flagOrPolarityIn = polarityVal;
    else if (flagOrPolarityOe) flagOrPolarityIn = flagOrPolarityOut;
    else if (flagPullDownEn) flagOrPolarityIn = 1'h0;
    else flagOrPolarityIn = ~lastFlag;
  end
  // level pin released in standby rests on its pull-up
  assign isoTxLevelSelectIn = releaseLevel ? 1'h1 : levelVal;
  assign enableOrPhaseIn = fwdVal;
  assign roleSelectIn = roleVal;
endmodule : host_mcu_model

// *** dual_role_config_pin_logic_test.sv ***
`timescale 1ns/10ps
module dual_role_config_pin_logic_test;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic sys_clk = 1'h0, rst_n = 1'h0, stateCfgLatch = 1'h0, stateNormal = 1'h0, stateStandby = 1'h0;
  logic wakeupStart = 1'h0, csAssert = 1'h0, frameIn = 1'h0, rxQueueNotEmpty = 1'h0;
  logic isoTxStart = 1'h0, isoTxDone = 1'h0, drivePolarity = 1'h0, polarityVal = 1'h0, shortOn = 1'h0;
  logic shortVal = 1'h0, fwdVal = 1'h1, levelVal = 1'h1, releaseLevel = 1'h0, roleVal = 1'h0;
  logic flagOrPolarityIn, flagOrPolarityOut, flagOrPolarityOe, flagPullDownEn, flagInBufEn;
  logic enableOrPhaseIn, phasePullUpEn, isoTxLevelSelectIn, roleSelectIn, roleInBufEn;
  logic masterRole, clkPolarity, clkPhase, txPushFrame, isoTxLevelHigh, flagShortTripped;
  int failCount = 0, checked = 0, expLevel, pend, k, i;
  logic [31:0] seed = 32'h322C07AF;
  logic fwdQ[$];
  // clock at 20 MHz
  always #25 sys_clk = ~sys_clk;
  dual_role_config_pin_logic u_dut (.sys_clk, .rst_n, .stateCfgLatch, .stateNormal, .stateStandby,
    .wakeupStart, .csAssert, .frameIn, .rxQueueNotEmpty, .isoTxStart, .isoTxDone, .flagOrPolarityIn,
    .flagOrPolarityOut, .flagOrPolarityOe, .flagPullDownEn, .flagInBufEn, .enableOrPhaseIn, .phasePullUpEn,
    .isoTxLevelSelectIn, .roleSelectIn, .roleInBufEn, .masterRole, .clkPolarity, .clkPhase, .txPushFrame,
    .isoTxLevelHigh, .flagShortTripped);
  host_mcu_model u_host (.sys_clk, .flagOrPolarityOut, .flagOrPolarityOe, .flagPullDownEn, .drivePolarity,
    .polarityVal, .shortOn, .shortVal, .fwdVal, .levelVal, .releaseLevel, .roleVal, .flagOrPolarityIn,
    .enableOrPhaseIn, .isoTxLevelSelectIn, .roleSelectIn);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input string name, input logic seen, input logic exp);
    checked++;
    if (seen !== exp) begin
      failCount++;
      $display("mismatch %s expected %b seen %b", name, exp, seen);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : cyc
  // one-cycle event pulse: 0 select, 1 frame, 2 iso start, 3 iso done, 4 wakeup
  task automatic pulse(input int p);
    @(posedge sys_clk);
    case (p)
      0: csAssert <= 1'h1;
      1: frameIn <= 1'h1;
      2: isoTxStart <= 1'h1;
      3: isoTxDone <= 1'h1;
      default: wakeupStart <= 1'h1;
    endcase
    @(posedge sys_clk);
    {csAssert, frameIn, isoTxStart, isoTxDone, wakeupStart} <= 5'h00;
    #1;
  endtask : pulse
  // reset, straps set up well ahead, then config latch and normal state
  task automatic configure(input logic role, input logic pol, input logic ph, input logic lvl);
    cyc(1);
    rst_n <= 1'h0;
    {stateNormal, stateStandby} <= 2'h0;
    {roleVal, drivePolarity, polarityVal, fwdVal, levelVal} <= {role, role, pol, ph, lvl};
    cyc(20);
    #1 chk("inbuf", flagInBufEn, 1'h1);
    cyc(1);
    rst_n <= 1'h1;
    stateCfgLatch <= 1'h1;
    cyc(4);
    #1 chk("pulldown", flagPullDownEn, 1'h1);
    chk("rolebuf", roleInBufEn, 1'h1);
    chk("pullup", phasePullUpEn, 1'h1);
    cyc(4);
    stateCfgLatch <= 1'h0;
    stateNormal <= 1'h1;
    expLevel = lvl;
    pend = lvl;
    cyc(2);
    #1 chk("role", masterRole, role);
    chk("level", isoTxLevelHigh, 1'(expLevel));
    chk("drvon", flagOrPolarityOe, ~role);
    chk("rolebuf", roleInBufEn, 1'h0);
    chk("pulldown", flagPullDownEn, 1'h1);
    chk("pullup", phasePullUpEn, 1'h1);
  endtask : configure
  // one frame: forward pin held from well before select until after hold time
  task automatic frame(input logic v, input logic flip);
    cyc(1);
    fwdVal <= v;
    cyc(20);
    pulse(0);
    fwdQ.push_back(v);
    cyc(6);
    if (flip) fwdVal <= ~v;
    pulse(1);
    chk("push", txPushFrame, fwdQ.pop_front());
  endtask : frame
  // slave select capturing a new level into pending
  task automatic levelCs(input logic v);
    cyc(1);
    levelVal <= v;
    cyc(20);
    pulse(0);
    pend = v;
  endtask : levelCs
  // ----------------------------------------
  // verdict
  // ----------------------------------------
  task automatic close_out;
    $display("checks %0d mismatches %0d", checked, failCount);
    if (failCount == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out
  // watchdog well beyond the few hundred cycles the tests need
  initial begin
    cyc(8000);
    failCount++;
    close_out();
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    configure(1'h0, 1'h0, 1'h1, 1'h1);
    // flag follows the random queue state
    for (i = 0; i < 40; i++) begin
      cyc(1);
      seed = lfsr(seed);
      rxQueueNotEmpty <= seed[0];
      cyc(1);
      #1 chk("flag", flagOrPolarityOut, rxQueueNotEmpty);
    end
    $display("test flag done");
    frame(1'h1, 1'h0);
    frame(1'h0, 1'h1);
    frame(1'h1, 1'h0);
    $display("test forward done");
    levelCs(1'h1);
    levelCs(1'h0);
    #1 chk("level held", isoTxLevelHigh, 1'(expLevel));
    pulse(3);
    expLevel = pend;
    chk("level newest", isoTxLevelHigh, 1'(expLevel));
    levelCs(1'h1);
    pulse(3);
    chk("level high", isoTxLevelHigh, 1'h1);
    $display("test level done");
    cyc(1);
    rxQueueNotEmpty <= 1'h0;
    cyc(4);
    {shortOn, shortVal} <= 2'h3;
    cyc(90);
    #1 chk("early trip", flagShortTripped, 1'h0);
    cyc(20);
    #1 chk("trip", flagShortTripped, 1'h1);
    chk("drv off", flagOrPolarityOe, 1'h0);
    cyc(1);
    shortOn <= 1'h0;
    cyc(10);
    #1 chk("stays off", flagOrPolarityOe, 1'h0);
    cyc(1);
    {stateNormal, stateStandby, releaseLevel} <= 3'h3;
    cyc(3);
    #1 chk("pullup sb", phasePullUpEn, 1'h0);
    chk("pulldown sb", flagPullDownEn, 1'h0);
    cyc(1);
    {releaseLevel, levelVal} <= 2'h0;
    cyc(5);
    pulse(4);
    chk("wake level", isoTxLevelHigh, 1'h0);
    chk("trip clear", flagShortTripped, 1'h0);
    cyc(1);
    {stateNormal, stateStandby} <= 2'h2;
    cyc(2);
    #1 chk("drv back", flagOrPolarityOe, 1'h1);
    $display("test short and wakeup done");
    for (k = 0; k < 2; k++) begin
      configure(1'h1, 1'(k), 1'(1 - k), 1'(k));
      chk("polarity", clkPolarity, 1'(k));
      chk("phase", clkPhase, 1'(1 - k));
      cyc(1);
      levelVal <= 1'(1 - k);
      rxQueueNotEmpty <= 1'h1;
      cyc(20);
      #1 chk("master hold", isoTxLevelHigh, 1'(k));
      chk("master drv", flagOrPolarityOe, 1'h0);
      pulse(2);
      chk("master level", isoTxLevelHigh, 1'(1 - k));
      $display("test master %0d done", k);
    end
    close_out();
  end
endmodule : dual_role_config_pin_logic_test
